//--- rtl/cpu_status_params.svh
// Constants for the core status and pointer registers.
// Assumes inclusion by bare name from the rtl folder.
`ifndef CPU_STATUS_PARAMS_SVH
`define CPU_STATUS_PARAMS_SVH
`define FLAG_CARRY_BIT      0
`define FLAG_AUX_BIT        1
`define FLAG_ZERO_BIT       2
`define FLAG_OVERFLOW_BIT   3
`define FLAG_POWER_DOWN_BIT 4
`define FLAG_TIMEOUT_BIT    5
`define PC_WIDTH            13
`define PC_LOW_WIDTH        8
`define PC_RESET            13'h0000
`define BYTE_ZERO           8'h00
`define NIBBLE_TOP          3
`define BYTE_TOP            7
`endif

//--- rtl/cpu_status_pkg.sv
// Types shared by the core status and pointer register files.
// Assumes the params header is included alongside.
package cpu_status_pkg;
    typedef enum logic [3:0] {
        ALU_NONE  = 4'h0,
        ALU_ADD   = 4'h1,
        ALU_ADC   = 4'h2,
        ALU_SUB   = 4'h3,
        ALU_SBC   = 4'h4,
        ALU_AND   = 4'h5,
        ALU_OR    = 4'h6,
        ALU_XOR   = 4'h7,
        ALU_RLC   = 4'h8,
        ALU_RRC   = 4'h9,
        ALU_INC   = 4'hA,
        ALU_DEC   = 4'hB
    } alu_op_e;

    typedef enum logic [1:0] {
        SEQ_RUN   = 2'h1,
        SEQ_DUMMY = 2'h2
    } seq_state_e;
endpackage : cpu_status_pkg

//--- rtl/flag_bus_if.sv
// Carries the ALU flag results from the flag unit to the register top.
// Assumes one clock domain; purely combinational signals.
`timescale 1ns/1ns
interface flag_bus_if;
    logic       carry;
    logic       aux_carry;
    logic       zero;
    logic       overflow;
    logic [7:0] result;
    modport producer (output carry, output aux_carry, output zero, output overflow,
                      output result);
    modport consumer (input carry, input aux_carry, input zero, input overflow,
                      input result);
endinterface : flag_bus_if

//--- rtl/alu_flag_unit.sv
// Eight-bit ALU that produces a result and the four arithmetic flags.
// Assumes operands are stable for the cycle in which the op is applied.
`timescale 1ns/1ns
`include "cpu_status_params.svh"
module alu_flag_unit (
    input  wire logic                   carry_in_i,
    input  wire cpu_status_pkg::alu_op_e op_i,
    input  wire logic [7:0]             operand_a_i,
    input  wire logic [7:0]             operand_b_i,
    flag_bus_if.producer                flags
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] low7_sum;
    logic [7:0] b_eff;
    logic       cin;

    always_comb begin
        b_eff    = operand_b_i;
        cin      = 1'b0;
        unique case (op_i)
            cpu_status_pkg::ALU_ADC: cin = carry_in_i;
            // Subtraction adds the complement; carry out set means no borrow.
            cpu_status_pkg::ALU_SUB: begin
                b_eff = ~operand_b_i;
                cin   = 1'b1;
            end
            cpu_status_pkg::ALU_SBC: begin
                b_eff = ~operand_b_i;
                cin   = carry_in_i;
            end
            cpu_status_pkg::ALU_INC: begin
                b_eff = `BYTE_ZERO;
                cin   = 1'b1;
            end
            cpu_status_pkg::ALU_DEC: b_eff = 8'hFF;
            default: ;
        endcase
        sum      = {1'b0, operand_a_i} + {1'b0, b_eff} + {8'h00, cin};
        low_sum  = {1'b0, operand_a_i[`NIBBLE_TOP:0]} + {1'b0, b_eff[`NIBBLE_TOP:0]}
                 + {4'h0, cin};
        low7_sum = {1'b0, operand_a_i[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
        flags.result    = sum[7:0];
        flags.carry     = sum[8];                                  // [RQ8]
        flags.aux_carry = low_sum[4];                              // [RQ9]
        flags.overflow  = low7_sum[`BYTE_TOP] ^ sum[8];            // [RQ11]
        unique case (op_i)
            cpu_status_pkg::ALU_AND: flags.result = operand_a_i & operand_b_i;
            cpu_status_pkg::ALU_OR:  flags.result = operand_a_i | operand_b_i;
            cpu_status_pkg::ALU_XOR: flags.result = operand_a_i ^ operand_b_i;
            cpu_status_pkg::ALU_RLC: begin
                flags.result = {operand_a_i[6:0], carry_in_i};
                flags.carry  = operand_a_i[`BYTE_TOP];              // [RQ8]
            end
            cpu_status_pkg::ALU_RRC: begin
                flags.result = {carry_in_i, operand_a_i[7:1]};
                flags.carry  = operand_a_i[0];                      // [RQ8]
            end
            default: ;
        endcase
        flags.zero = (flags.result == `BYTE_ZERO);                  // [RQ10]
    end
endmodule : alu_flag_unit

//--- rtl/cpu_status_and_pointer_regs.sv
// Core special registers: low program counter, table pointers, table high byte
// and the status flags. Assumes the instruction decoder drives one-cycle
// strobes synchronous to clk_i and program memory answers in the same cycle.
// Overview of operation
// RQ1: Writing program_counter_low replaces only the low eight PC bits, staying in the page.
// RQ2: Such a jump inserts one dummy cycle before the target instruction runs.
// RQ3: The two table pointers form the table read address and may be changed like any register.
// RQ4: A table read puts the word's high byte in table_high_byte and hands out the low byte.
// RQ5: Status writes change only the arithmetic flags; the two system flags are read-only.
// RQ6: The watchdog time-out flag clears at power-up, watchdog clear or power down, sets on time-out.
// RQ7: The power-down flag clears at power-up or watchdog clear and sets on power down.
// RQ8: Carry follows addition carry, subtraction no-borrow and the rotated-out bit.
// RQ9: Aux carry follows carry out of the low nibble or no nibble borrow.
// RQ10: Zero is set exactly when the result is zero.
// RQ11: Overflow is carry into the top bit exclusive-or carry out of it.
// RQ12: Calls and interrupts push only the return address, never status.
// RQ13: Status bits 7 and 6 read zero; system flags reset to zero, arithmetic flags undefined.
`timescale 1ns/1ns
`include "cpu_status_params.svh"
module cpu_status_and_pointer_regs (
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    pc_advance_i,
    input  wire logic                    pc_load_i,
    input  wire logic [12:0]             pc_load_value_i,
    input  wire logic                    page_jump_i,
    input  wire logic [7:0]              page_jump_byte_i,
    input  wire logic                    ptr_lo_we_i,
    input  wire logic                    ptr_hi_we_i,
    input  wire logic [7:0]              pointer_write_data_i,
    input  wire logic                    table_read_i,
    input  wire logic [15:0]             program_word_i,
    input  wire logic                    status_write_i,
    input  wire logic [7:0]              status_write_data_i,
    input  wire logic                    alu_update_i,
    input  wire cpu_status_pkg::alu_op_e alu_op_i,
    input  wire logic [7:0]              operand_a_i,
    input  wire logic [7:0]              operand_b_i,
    input  wire logic                    watchdog_clear_instruction_i,
    input  wire logic                    power_down_instruction_i,
    input  wire logic                    watchdog_timeout_i,
    output logic [12:0]                  program_counter_o,
    output logic [12:0]                  return_address_o,
    output logic                         dummy_cycle_o,
    output logic [15:0]                  table_address_o,
    output logic [7:0]                   table_low_byte_o,
    output logic                         table_low_valid_o,
    output logic [7:0]                   table_pointer_low_o,
    output logic [7:0]                   table_pointer_high_o,
    output logic [7:0]                   table_high_byte_o,
    output logic [7:0]                   alu_result_o,
    output logic [7:0]                   core_flags_o
);
    flag_bus_if fbus ();

    logic [12:0] program_counter;
    logic [12:0] next_program_counter;
    cpu_status_pkg::seq_state_e seq_state;
    cpu_status_pkg::seq_state_e next_seq_state;
    logic [7:0]  table_pointer_low;
    logic [7:0]  next_table_pointer_low;
    logic [7:0]  table_pointer_high;
    logic [7:0]  next_table_pointer_high;
    logic [7:0]  table_high_byte;
    logic [7:0]  next_table_high_byte;
    logic [7:0]  table_low_byte;
    logic [7:0]  next_table_low_byte;
    logic        table_low_valid;
    logic        next_table_low_valid;
    logic [7:0]  alu_result;
    logic [7:0]  next_alu_result;
    logic [3:0]  arith_flags;
    logic [3:0]  next_arith_flags;
    logic        watchdog_timeout_flag;
    logic        next_watchdog_timeout_flag;
    logic        power_down_flag;
    logic        next_power_down_flag;

    alu_flag_unit u_alu (
        .carry_in_i  (arith_flags[`FLAG_CARRY_BIT]),
        .op_i        (alu_op_i),
        .operand_a_i (operand_a_i),
        .operand_b_i (operand_b_i),
        .flags       (fbus)
    );

    // Program counter and dummy-cycle sequencer.
    always_comb begin
        next_program_counter = program_counter;
        next_seq_state       = seq_state;
        unique case (seq_state)
            cpu_status_pkg::SEQ_RUN: begin
                if (page_jump_i) begin
                    next_program_counter = {program_counter[`PC_WIDTH-1:`PC_LOW_WIDTH],
                                            page_jump_byte_i};          // [RQ1]
                    next_seq_state       = cpu_status_pkg::SEQ_DUMMY;   // [RQ2]
                end else if (pc_load_i) begin
                    next_program_counter = pc_load_value_i;
                end else if (pc_advance_i) begin
                    next_program_counter = program_counter + 13'h0001;
                end
            end
            // The pipeline refills here, so the counter holds for one cycle.
            cpu_status_pkg::SEQ_DUMMY: next_seq_state = cpu_status_pkg::SEQ_RUN; // [RQ2]
            default: next_seq_state = cpu_status_pkg::SEQ_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            program_counter <= `PC_RESET;
            seq_state       <= cpu_status_pkg::SEQ_RUN;
        end else begin
            program_counter <= next_program_counter;
            seq_state       <= next_seq_state;
        end
    end

    // Table pointers and table read capture.
    always_comb begin
        next_table_pointer_low  = table_pointer_low;
        next_table_pointer_high = table_pointer_high;
        next_table_high_byte    = table_high_byte;
        next_table_low_byte     = table_low_byte;
        next_table_low_valid    = 1'b0;
        if (ptr_lo_we_i) begin
            next_table_pointer_low = pointer_write_data_i;              // [RQ3]
        end
        if (ptr_hi_we_i) begin
            next_table_pointer_high = pointer_write_data_i;             // [RQ3]
        end
        if (table_read_i) begin
            next_table_high_byte = program_word_i[15:8];                // [RQ4]
            next_table_low_byte  = program_word_i[7:0];                 // [RQ4]
            next_table_low_valid = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            table_pointer_low  <= `BYTE_ZERO;
            table_pointer_high <= `BYTE_ZERO;
            table_high_byte    <= `BYTE_ZERO;
            table_low_byte     <= `BYTE_ZERO;
            table_low_valid    <= 1'b0;
        end else begin
            table_pointer_low  <= next_table_pointer_low;
            table_pointer_high <= next_table_pointer_high;
            table_high_byte    <= next_table_high_byte;
            table_low_byte     <= next_table_low_byte;
            table_low_valid    <= next_table_low_valid;
        end
    end

    // Status flags. An ALU update wins over a plain status write in the same
    // cycle for the flags its op updates, as the instruction result is the later effect.
    always_comb begin
        next_arith_flags           = arith_flags;
        next_alu_result            = alu_result;
        next_watchdog_timeout_flag = watchdog_timeout_flag;
        next_power_down_flag       = power_down_flag;
        if (status_write_i) begin
            next_arith_flags = status_write_data_i[`FLAG_OVERFLOW_BIT:0]; // [RQ5]
        end
        if (alu_update_i) begin
            next_alu_result = fbus.result;
            next_arith_flags[`FLAG_ZERO_BIT] = fbus.zero;                  // [RQ10]
            if (alu_op_i != cpu_status_pkg::ALU_AND && alu_op_i != cpu_status_pkg::ALU_OR
                && alu_op_i != cpu_status_pkg::ALU_XOR
                && alu_op_i != cpu_status_pkg::ALU_NONE
                && alu_op_i != cpu_status_pkg::ALU_INC
                && alu_op_i != cpu_status_pkg::ALU_DEC) begin
                next_arith_flags[`FLAG_CARRY_BIT] = fbus.carry;           // [RQ8]
            end
            if (alu_op_i == cpu_status_pkg::ALU_ADD || alu_op_i == cpu_status_pkg::ALU_ADC
                || alu_op_i == cpu_status_pkg::ALU_SUB
                || alu_op_i == cpu_status_pkg::ALU_SBC) begin
                next_arith_flags[`FLAG_AUX_BIT]      = fbus.aux_carry;     // [RQ9]
                next_arith_flags[`FLAG_OVERFLOW_BIT] = fbus.overflow;      // [RQ11]
            end
        end
        if (watchdog_clear_instruction_i || power_down_instruction_i) begin
            next_watchdog_timeout_flag = 1'b0;                            // [RQ6]
        end
        // A time-out in the same cycle as a clear is not lost.
        if (watchdog_timeout_i) begin
            next_watchdog_timeout_flag = 1'b1;                            // [RQ6]
        end
        if (watchdog_clear_instruction_i) begin
            next_power_down_flag = 1'b0;                                  // [RQ7]
        end else if (power_down_instruction_i) begin
            next_power_down_flag = 1'b1;                                  // [RQ7]
        end
    end

    // Arithmetic flags power up undefined, so they take no reset value.
    always_ff @(posedge clk_i) begin
        arith_flags <= next_arith_flags;                                  // [RQ13]
        alu_result  <= next_alu_result;
        if (reset_i) begin
            watchdog_timeout_flag <= 1'b0;                                // [RQ13]
            power_down_flag       <= 1'b0;                                // [RQ13]
        end else begin
            watchdog_timeout_flag <= next_watchdog_timeout_flag;
            power_down_flag       <= next_power_down_flag;
        end
    end

    assign program_counter_o    = program_counter;
    // Only the address is offered for the stack; status is never pushed.
    assign return_address_o     = program_counter;                         // [RQ12]
    assign dummy_cycle_o        = (seq_state == cpu_status_pkg::SEQ_DUMMY); // [RQ2]
    assign table_address_o      = {table_pointer_high, table_pointer_low};  // [RQ3]
    assign table_low_byte_o     = table_low_byte;
    assign table_low_valid_o    = table_low_valid;
    assign table_pointer_low_o  = table_pointer_low;
    assign table_pointer_high_o = table_pointer_high;
    assign table_high_byte_o    = table_high_byte;
    assign alu_result_o         = alu_result;
    assign core_flags_o         = {2'b00, watchdog_timeout_flag, power_down_flag,
                                   arith_flags};                           // [RQ13]
endmodule : cpu_status_and_pointer_regs

//--- verif/cpu_status_and_pointer_regs_asserts.sv
// Concurrent checks on the ports of the core status and pointer registers.
// Assumes it is bound to the top module and shares its single clock and reset.
`timescale 1ns/1ns
module cpu_status_and_pointer_regs_asserts (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        pc_load_i,
    input wire logic        page_jump_i,
    input wire logic [7:0]  page_jump_byte_i,
    input wire logic        table_read_i,
    input wire logic [15:0] program_word_i,
    input wire logic        status_write_i,
    input wire logic [7:0]  status_write_data_i,
    input wire logic        alu_update_i,
    input wire logic        watchdog_clear_instruction_i,
    input wire logic        power_down_instruction_i,
    input wire logic        watchdog_timeout_i,
    input wire logic [12:0] program_counter_o,
    input wire logic        dummy_cycle_o,
    input wire logic [15:0] table_address_o,
    input wire logic [7:0]  table_low_byte_o,
    input wire logic        table_low_valid_o,
    input wire logic [7:0]  table_pointer_low_o,
    input wire logic [7:0]  table_pointer_high_o,
    input wire logic [7:0]  table_high_byte_o,
    input wire logic [7:0]  alu_result_o,
    input wire logic [7:0]  core_flags_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic sys_any;
    assign sys_any = watchdog_clear_instruction_i | power_down_instruction_i | watchdog_timeout_i;

    property p_page_jump;
        page_jump_i && !dummy_cycle_o |=>
            program_counter_o == {$past(program_counter_o[12:8]), $past(page_jump_byte_i)};
    endproperty
    a_page_jump: assert property (p_page_jump)
        else $error("page jump target wrong");
    property p_dummy;
        page_jump_i && !dummy_cycle_o |=> dummy_cycle_o ##1 !dummy_cycle_o;
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("dummy cycle not exactly one cycle");
    property p_dummy_hold;
        dummy_cycle_o |=> $stable(program_counter_o);
    endproperty
    a_dummy_hold: assert property (p_dummy_hold)
        else $error("counter moved during dummy cycle");
    property p_table_addr;
        table_address_o == {table_pointer_high_o, table_pointer_low_o};
    endproperty
    a_table_addr: assert property (p_table_addr)
        else $error("table address not formed from pointers");
    property p_table_read;
        table_read_i |=> table_low_valid_o && table_high_byte_o == $past(program_word_i[15:8])
            && table_low_byte_o == $past(program_word_i[7:0]);
    endproperty
    a_table_read: assert property (p_table_read)
        else $error("table word bytes misplaced");
    property p_status_write;
        status_write_i && !alu_update_i && !sys_any |=>
            core_flags_o[5:0] == {$past(core_flags_o[5:4]), $past(status_write_data_i[3:0])};
    endproperty
    a_status_write: assert property (p_status_write)
        else $error("status write touched system flags");
    property p_timeout_set;
        watchdog_timeout_i |=> core_flags_o[5];
    endproperty
    a_timeout_set: assert property (p_timeout_set)
        else $error("timeout flag not set");
    property p_timeout_clear;
        (watchdog_clear_instruction_i || power_down_instruction_i) && !watchdog_timeout_i
            |=> !core_flags_o[5];
    endproperty
    a_timeout_clear: assert property (p_timeout_clear)
        else $error("timeout flag not cleared");
    property p_power_down;
        power_down_instruction_i |=> core_flags_o[4] == !$past(watchdog_clear_instruction_i);
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power down flag wrong");
    property p_zero;
        alu_update_i |=> core_flags_o[2] == (alu_result_o == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag disagrees with result");
    property p_no_push;
        pc_load_i && !status_write_i && !alu_update_i && !sys_any |=> $stable(core_flags_o);
    endproperty
    a_no_push: assert property (p_no_push)
        else $error("flags changed on a call");
    property p_top_zero;
        core_flags_o[7:6] == 2'h0;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("status bits 7 and 6 not zero");
    property p_reset;
        disable iff (1'b0) reset_i |=> core_flags_o[5:4] == 2'h0 && program_counter_o == 13'h0000;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");

    c_jump: cover property (page_jump_i && !dummy_cycle_o);
    c_table: cover property (table_read_i);
    c_timeout: cover property (watchdog_timeout_i && watchdog_clear_instruction_i);
endmodule : cpu_status_and_pointer_regs_asserts

//--- verif/cpu_status_and_pointer_regs_tb.sv
// Self-checking bench for the core status and pointer registers.
// Assumes the rtl package and header are compiled first.
`timescale 1ns/1ns
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module cpu_status_and_pointer_regs_tb;
    logic clk_i, reset_i, pc_advance_i, pc_load_i, page_jump_i, ptr_lo_we_i, ptr_hi_we_i;
    logic table_read_i, status_write_i, alu_update_i, watchdog_clear_instruction_i;
    logic power_down_instruction_i, watchdog_timeout_i, dummy_cycle_o, table_low_valid_o;
    logic [12:0] pc_load_value_i, program_counter_o, return_address_o;
    logic [7:0] page_jump_byte_i, pointer_write_data_i, status_write_data_i, operand_a_i;
    logic [7:0] operand_b_i, table_low_byte_o, table_pointer_low_o, table_pointer_high_o;
    logic [7:0] table_high_byte_o, alu_result_o, core_flags_o;
    logic [15:0] program_word_i, table_address_o;
    cpu_status_pkg::alu_op_e alu_op_i;
    int fail_count = 0;
    int cmp_count = 0;

    cpu_status_and_pointer_regs u_cpu_status_and_pointer_regs (
        .clk_i(clk_i), .reset_i(reset_i), .pc_advance_i(pc_advance_i), .pc_load_i(pc_load_i),
        .pc_load_value_i(pc_load_value_i), .page_jump_i(page_jump_i),
        .page_jump_byte_i(page_jump_byte_i), .ptr_lo_we_i(ptr_lo_we_i),
        .ptr_hi_we_i(ptr_hi_we_i), .pointer_write_data_i(pointer_write_data_i),
        .table_read_i(table_read_i), .program_word_i(program_word_i),
        .status_write_i(status_write_i), .status_write_data_i(status_write_data_i),
        .alu_update_i(alu_update_i), .alu_op_i(alu_op_i), .operand_a_i(operand_a_i),
        .operand_b_i(operand_b_i), .watchdog_clear_instruction_i(watchdog_clear_instruction_i),
        .power_down_instruction_i(power_down_instruction_i),
        .watchdog_timeout_i(watchdog_timeout_i), .program_counter_o(program_counter_o),
        .return_address_o(return_address_o), .dummy_cycle_o(dummy_cycle_o),
        .table_address_o(table_address_o), .table_low_byte_o(table_low_byte_o),
        .table_low_valid_o(table_low_valid_o), .table_pointer_low_o(table_pointer_low_o),
        .table_pointer_high_o(table_pointer_high_o), .table_high_byte_o(table_high_byte_o),
        .alu_result_o(alu_result_o), .core_flags_o(core_flags_o));

    task give_verdict;
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // Strobes are one-cycle pulses, so every operation ends by dropping all of them.
    task tick;
        @(posedge clk_i);
        {pc_advance_i, pc_load_i, page_jump_i, ptr_lo_we_i, ptr_hi_we_i, table_read_i,
         status_write_i, alu_update_i, watchdog_timeout_i, power_down_instruction_i,
         watchdog_clear_instruction_i} <= '0;
        #1;
    endtask : tick
    task alu(input cpu_status_pkg::alu_op_e op, input logic [7:0] a, b, res, input logic [3:0] f);
        @(posedge clk_i);
        alu_update_i <= 1'b1;
        alu_op_i <= op;
        operand_a_i <= a;
        operand_b_i <= b;
        tick;
        `CHECK(alu_result_o, res)
        `CHECK(core_flags_o[3:0], f)
    endtask : alu
    // Bits of s: timeout, power down, watchdog clear.
    task flags_op(input logic st, input logic [7:0] d, input logic [2:0] s, input logic [7:0] e);
        @(posedge clk_i);
        status_write_i <= st;
        status_write_data_i <= d;
        {watchdog_timeout_i, power_down_instruction_i, watchdog_clear_instruction_i} <= s;
        tick;
        `CHECK(core_flags_o, e)
    endtask : flags_op

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #4000;
        fail_count++;
        give_verdict;
    end
    initial begin
        {pc_advance_i, pc_load_i, page_jump_i, ptr_lo_we_i, ptr_hi_we_i, table_read_i} = '0;
        {status_write_i, alu_update_i, watchdog_clear_instruction_i} = '0;
        {power_down_instruction_i, watchdog_timeout_i, pc_load_value_i} = '0;
        {page_jump_byte_i, pointer_write_data_i, status_write_data_i} = '0;
        {operand_a_i, operand_b_i, program_word_i} = '0;
        alu_op_i = cpu_status_pkg::ALU_NONE;
        reset_i = 1'b1;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        `CHECK(core_flags_o[7:4], 4'h0)
        `CHECK(program_counter_o, 13'h0000)
        @(posedge clk_i);
        pc_load_i <= 1'b1;
        pc_load_value_i <= 13'h1F00;
        tick;
        @(posedge clk_i);
        page_jump_i <= 1'b1;
        page_jump_byte_i <= 8'h34;
        // The strobe stays up into the dummy cycle, where the second write must be refused.
        @(posedge clk_i);
        page_jump_byte_i <= 8'h56;
        #1;
        `CHECK(program_counter_o, 13'h1F34)
        `CHECK(dummy_cycle_o, 1'b1)
        tick;
        `CHECK(program_counter_o, 13'h1F34)
        `CHECK(dummy_cycle_o, 1'b0)
        @(posedge clk_i);
        pc_advance_i <= 1'b1;
        tick;
        `CHECK(program_counter_o, 13'h1F35)
        @(posedge clk_i);
        ptr_lo_we_i <= 1'b1;
        ptr_hi_we_i <= 1'b1;
        pointer_write_data_i <= 8'h12;
        tick;
        `CHECK(table_address_o, 16'h1212)
        @(posedge clk_i);
        ptr_hi_we_i <= 1'b1;
        pointer_write_data_i <= 8'h34;
        tick;
        `CHECK(table_address_o, 16'h3412)
        `CHECK({table_pointer_high_o, table_pointer_low_o}, 16'h3412)
        @(posedge clk_i);
        table_read_i <= 1'b1;
        program_word_i <= 16'hABCD;
        tick;
        `CHECK({table_high_byte_o, table_low_byte_o, table_low_valid_o}, {16'hABCD, 1'b1})
        tick;
        `CHECK(table_low_valid_o, 1'b0)
        alu(cpu_status_pkg::ALU_ADD, 8'hFF, 8'h01, 8'h00, 4'h7);
        alu(cpu_status_pkg::ALU_ADD, 8'h7F, 8'h01, 8'h80, 4'hA);
        alu(cpu_status_pkg::ALU_SUB, 8'h05, 8'h03, 8'h02, 4'h3);
        alu(cpu_status_pkg::ALU_SUB, 8'h03, 8'h05, 8'hFE, 4'h0);
        alu(cpu_status_pkg::ALU_SUB, 8'h80, 8'h01, 8'h7F, 4'h9);
        alu(cpu_status_pkg::ALU_ADC, 8'h01, 8'h01, 8'h03, 4'h0);
        alu(cpu_status_pkg::ALU_SBC, 8'h05, 8'h02, 8'h02, 4'h3);
        alu(cpu_status_pkg::ALU_AND, 8'hF0, 8'h0F, 8'h00, 4'h7);
        alu(cpu_status_pkg::ALU_OR, 8'h01, 8'h02, 8'h03, 4'h3);
        alu(cpu_status_pkg::ALU_XOR, 8'hAA, 8'h55, 8'hFF, 4'h3);
        alu(cpu_status_pkg::ALU_RLC, 8'h40, 8'h00, 8'h81, 4'h2);
        alu(cpu_status_pkg::ALU_RRC, 8'h01, 8'h00, 8'h00, 4'h7);
        alu(cpu_status_pkg::ALU_INC, 8'hFF, 8'h01, 8'h00, 4'h7);
        alu(cpu_status_pkg::ALU_DEC, 8'h05, 8'h01, 8'h04, 4'h3);
        alu(cpu_status_pkg::ALU_NONE, 8'h00, 8'h00, 8'h00, 4'h7);
        flags_op(1'b1, 8'hFF, 3'b000, 8'h0F);
        flags_op(1'b1, 8'hF0, 3'b000, 8'h00);
        flags_op(1'b0, 8'h00, 3'b100, 8'h20);
        flags_op(1'b0, 8'h00, 3'b010, 8'h10);
        flags_op(1'b0, 8'h00, 3'b100, 8'h30);
        flags_op(1'b1, 8'h05, 3'b000, 8'h35);
        flags_op(1'b0, 8'h00, 3'b001, 8'h05);
        flags_op(1'b0, 8'h00, 3'b101, 8'h25);
        flags_op(1'b0, 8'h00, 3'b011, 8'h05);
        @(posedge clk_i);
        pc_load_i <= 1'b1;
        pc_load_value_i <= 13'h0ABC;
        tick;
        `CHECK(core_flags_o, 8'h05)
        `CHECK(return_address_o, 13'h0ABC)
        give_verdict;
    end
endmodule : cpu_status_and_pointer_regs_tb

bind cpu_status_and_pointer_regs cpu_status_and_pointer_regs_asserts u_cpu_status_and_pointer_regs_asserts (
    .clk_i(clk_i), .reset_i(reset_i), .pc_load_i(pc_load_i), .page_jump_i(page_jump_i),
    .page_jump_byte_i(page_jump_byte_i), .table_read_i(table_read_i),
    .program_word_i(program_word_i), .status_write_i(status_write_i),
    .status_write_data_i(status_write_data_i), .alu_update_i(alu_update_i),
    .watchdog_clear_instruction_i(watchdog_clear_instruction_i),
    .power_down_instruction_i(power_down_instruction_i),
    .watchdog_timeout_i(watchdog_timeout_i), .program_counter_o(program_counter_o),
    .dummy_cycle_o(dummy_cycle_o), .table_address_o(table_address_o),
    .table_low_byte_o(table_low_byte_o), .table_low_valid_o(table_low_valid_o),
    .table_pointer_low_o(table_pointer_low_o), .table_pointer_high_o(table_pointer_high_o),
    .table_high_byte_o(table_high_byte_o), .alu_result_o(alu_result_o),
    .core_flags_o(core_flags_o));
